/* include/dsc_regs.svh */
// Constants for the data steering and byte conversion block
//
// Behaviour
// - ROM output enable low at reset selects 8-bit ROM with conversion cycles.
// - Word read of 8-bit ROM: low byte at SA0=0 latched, then SA0=1 high byte.
// - Each ROM byte access waits the programmed wait states; ready after second.
// - Memory writes generate parity for low byte and high byte separately.
// - Read parity error raises NMI only with port and chipset parity enables set.
// - External data-controller mode bit selects buffer controls suited to it.
// - Separate active-low enables for low, high and swap buffers.
// - Processor read direction low passes system bus to processor bus.
// - Swap direction low moves bits 0-7 to 8-15, high the reverse.
// - Peripheral buffer read low passes peripheral bus onto system bus.
// - Memory direction low passes memory data to processor, high the reverse.
// - Word read of 8-bit ROM pulses latch clock, then asserts latched select.
// - Byte high enable is input in master mode, driven otherwise.
// - Processor mode asserts byte high enable when high byte is accessed.
// - 8-bit DMA drives byte high enable as inverse SA0; 16-bit DMA low.
// - ROM output enable asserted low for any selected ROM range access.
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_WAIT_W 4
`define DSC_RST_ROM8 1'b0
`endif

/* include/dsc_pkg.sv */
// Types for the data steering and byte conversion block
package dsc_pkg;
  typedef enum logic [1:0] {DSC_MODE_CPU, DSC_MODE_DMA8, DSC_MODE_DMA16,
    DSC_MODE_MASTER} dsc_mode_t;
  typedef enum logic [2:0] {DSC_IDLE, DSC_LO_WAIT, DSC_LO_LATCH, DSC_HI_WAIT,
    DSC_DONE} dsc_state_t;
endpackage

/* design/dsc_data_steer.sv */
// Data steering, byte conversion, byte high enable and parity logic
`timescale 1ns/100ps
`include "dsc_regs.svh"
module dsc_data_steer #(
  parameter int WAIT_W = `DSC_WAIT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire dsc_pkg::dsc_mode_t mode,
  input wire logic cycle_active,
  input wire logic cycle_start,
  input wire logic cycle_read,
  input wire logic cycle_mem,
  input wire logic cycle_local_mem,
  input wire logic cycle_peripheral,
  input wire logic cycle_byte_port,
  input wire logic rom_hit,
  input wire logic cpu_ble_n,
  input wire logic cpu_bhe_n,
  input wire logic sa0_in,
  input wire logic [WAIT_W-1:0] rom_wait_states,
  input wire logic ext_data_controller,
  input wire logic system_port_parity_check_enable,
  input wire logic chipset_parity_enable,
  input wire logic [15:0] mem_data_in,
  input wire logic [1:0] mem_parity_in,
  input wire logic rom_output_enable_n_pin,
  input wire logic byte_high_enable_n_in,
  output logic rom_output_enable_n,
  output logic rom8_mode,
  output logic sa0_out,
  output logic rom_ready,
  output logic low_byte_parity,
  output logic high_byte_parity,
  output logic parity_nmi,
  output logic low_byte_buffer_enable_n,
  output logic high_byte_buffer_enable_n,
  output logic swap_buffer_enable_n,
  output logic processor_read_direction_n,
  output logic swap_direction,
  output logic peripheral_buffer_read_n,
  output logic memory_data_direction_n,
  output logic low_byte_latch_clock,
  output logic latched_byte_select,
  output logic byte_high_enable_n_out,
  output logic byte_high_enable_n_oe
);
  // ==========================================================
  // Reset strap of the ROM width
  // The strap pin passes three flops; sampled while reset holds.
  logic rom_s1_r, rom_s2_r, rom_s3_r, rom8_r;
  always_ff @(posedge clk)
  begin
    rom_s1_r <= rom_output_enable_n_pin;
    rom_s2_r <= rom_s1_r;
    rom_s3_r <= rom_s2_r;
  end
  always_ff @(posedge clk)
  begin
    if (reset && (rom_s2_r == rom_s3_r))
      rom8_r <= ~rom_s3_r;
  end
  assign rom8_mode = rom8_r;

  // ==========================================================
  // ROM conversion sequencer
  // One wait count serves both bytes; there is no separate setting per byte.
  dsc_pkg::dsc_state_t st_r, st_nxt;
  logic [WAIT_W-1:0] wcnt_r, wcnt_nxt;
  logic sa0_r, sa0_nxt, rdy_r, rdy_nxt;
  wire conv_go = cycle_start && rom_hit && cycle_read && rom8_r && (mode == dsc_pkg::DSC_MODE_CPU)
                 && !cpu_ble_n && !cpu_bhe_n;
  wire wait_done = (wcnt_r == '0);
  always_comb
  begin
    st_nxt = st_r;
    wcnt_nxt = wcnt_r;
    sa0_nxt = sa0_r;
    rdy_nxt = 1'b0;
    case (st_r)
      dsc_pkg::DSC_IDLE:
        if (conv_go)
        begin
          st_nxt = dsc_pkg::DSC_LO_WAIT;
          wcnt_nxt = rom_wait_states;
          sa0_nxt = 1'b0;
        end
      dsc_pkg::DSC_LO_WAIT:
        if (wait_done)
          st_nxt = dsc_pkg::DSC_LO_LATCH;
        else
          wcnt_nxt = wcnt_r - 1'b1;
      dsc_pkg::DSC_LO_LATCH:
      begin
        st_nxt = dsc_pkg::DSC_HI_WAIT;
        wcnt_nxt = rom_wait_states;
        sa0_nxt = 1'b1;
      end
      dsc_pkg::DSC_HI_WAIT:
        if (wait_done)
        begin
          st_nxt = dsc_pkg::DSC_DONE;
          rdy_nxt = 1'b1;
        end
        else
          wcnt_nxt = wcnt_r - 1'b1;
      default:
      begin
        st_nxt = dsc_pkg::DSC_IDLE;
        sa0_nxt = 1'b0;
      end
    endcase
    if (!cycle_active && st_r != dsc_pkg::DSC_IDLE && st_r != dsc_pkg::DSC_DONE)
    begin
      // A dropped cycle must not leave a stale ready or SA0 behind
      st_nxt = dsc_pkg::DSC_IDLE;
      sa0_nxt = 1'b0;
      rdy_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= dsc_pkg::DSC_IDLE;
      wcnt_r <= '0;
      sa0_r <= 1'b0;
      rdy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      wcnt_r <= wcnt_nxt;
      sa0_r <= sa0_nxt;
      rdy_r <= rdy_nxt;
    end
  end
  wire conv_busy = (st_r != dsc_pkg::DSC_IDLE);
  assign sa0_out = conv_busy ? sa0_r : sa0_in;
  assign rom_ready = rdy_r;

  // ==========================================================
  // ROM conversion strobes; byte port reads only extend the select
  // Latch clock pulses at end of low byte, select holds for the high byte.
  logic lclk_r, lsel_r;
  wire port_conv = cycle_byte_port && !cpu_ble_n && !cpu_bhe_n && cycle_read;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lclk_r <= 1'b0;
      lsel_r <= 1'b0;
    end
    else
    begin
      lclk_r <= (st_nxt == dsc_pkg::DSC_LO_LATCH) && (st_r == dsc_pkg::DSC_LO_WAIT);
      lsel_r <= (st_nxt == dsc_pkg::DSC_HI_WAIT || st_nxt == dsc_pkg::DSC_DONE
                 || (lsel_r && port_conv)) && cycle_active;
    end
  end
  assign low_byte_latch_clock = lclk_r;
  assign latched_byte_select = lsel_r;

  // ==========================================================
  // ROM decode output
  assign rom_output_enable_n = ~(cycle_active && rom_hit && !reset);

  // ==========================================================
  // Buffer enables and directions
  // Enables off while idle so no two buffers fight on a bus.
  wire bus_ok = cycle_active && !reset;
  wire sys_cycle = bus_ok && !cycle_local_mem && !(rom_hit && ext_data_controller);
  wire swap_need = sys_cycle && conv_busy ? 1'b0 : (sys_cycle && cpu_ble_n && !cpu_bhe_n
                   && mode == dsc_pkg::DSC_MODE_CPU && cycle_byte_port);
  assign low_byte_buffer_enable_n = ~(sys_cycle && !cpu_ble_n);
  assign high_byte_buffer_enable_n = ~(sys_cycle && !cpu_bhe_n && !cycle_byte_port);
  assign swap_buffer_enable_n = ~swap_need;
  assign processor_read_direction_n = ~cycle_read;
  assign swap_direction = ~cycle_read;
  assign peripheral_buffer_read_n = ~(cycle_peripheral && cycle_read);
  assign memory_data_direction_n = ~(cycle_local_mem && cycle_read);

  // ==========================================================
  // Byte high enable
  // Master mode leaves the pin to the bus owner; the sense input is spare.
  logic bhe_nxt;
  always_comb
  begin
    case (mode)
      dsc_pkg::DSC_MODE_DMA8: bhe_nxt = sa0_in ? 1'b0 : 1'b1;
      dsc_pkg::DSC_MODE_DMA16: bhe_nxt = 1'b0;
      default: bhe_nxt = cpu_bhe_n;
    endcase
  end
  assign byte_high_enable_n_oe = (mode != dsc_pkg::DSC_MODE_MASTER);
  assign byte_high_enable_n_out = bhe_nxt;

  // ==========================================================
  // Parity
  // Even parity per byte; the write side uses the same xor tree as the check.
  logic perr_r;
  assign low_byte_parity = ^mem_data_in[7:0];
  assign high_byte_parity = ^mem_data_in[15:8];
  wire par_err = cycle_mem && cycle_read && cycle_active
                 && ((^mem_data_in[7:0] != mem_parity_in[0])
                  || (^mem_data_in[15:8] != mem_parity_in[1]));
  always_ff @(posedge clk)
  begin
    if (reset)
      perr_r <= 1'b0;
    else
      perr_r <= par_err && system_port_parity_check_enable && chipset_parity_enable;
  end
  assign parity_nmi = perr_r;

  // ==========================================================
  // Checks
  // Sequencer checks sleep in reset; buffer and pin checks hold through it
  property p_ready_after_hi;
    @(posedge clk) disable iff (reset)
      rom_ready |-> $past(sa0_r) && sa0_out;
  endproperty
  a_ready_after_hi: assert property (p_ready_after_hi)
    else $error("ready without high byte");
  // Ready is a single pulse so the processor never sees two ends of one cycle
  property p_ready_pulse;
    @(posedge clk) disable iff (reset)
      rom_ready |=> !rom_ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_abort_quiet;
    @(posedge clk) disable iff (reset)
      (!cycle_active && conv_busy && st_r != dsc_pkg::DSC_DONE) |=> !rom_ready && !conv_busy;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("ready after dropped cycle");
  property p_first_low;
    @(posedge clk) disable iff (reset)
      (st_r == dsc_pkg::DSC_IDLE && conv_go) |=> !sa0_out;
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("conversion not low first");
  property p_hi_second;
    @(posedge clk) disable iff (reset)
      low_byte_latch_clock && cycle_active |=> sa0_out;
  endproperty
  a_hi_second: assert property (p_hi_second)
    else $error("high byte not addressed after latch");
  property p_nmi_gate;
    @(posedge clk) disable iff (reset)
      parity_nmi |-> $past(system_port_parity_check_enable) && $past(chipset_parity_enable);
  endproperty
  a_nmi_gate: assert property (p_nmi_gate)
    else $error("nmi without enables");
  property p_par_err;
    @(posedge clk) disable iff (reset)
      cycle_mem && cycle_read && cycle_active && system_port_parity_check_enable
        && chipset_parity_enable && ({high_byte_parity, low_byte_parity} != mem_parity_in)
        |=> parity_nmi;
  endproperty
  a_par_err: assert property (p_par_err)
    else $error("parity error not reported");
  property p_idle_off;
    @(posedge clk) !cycle_active |-> low_byte_buffer_enable_n && high_byte_buffer_enable_n
      && swap_buffer_enable_n;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("buffer on while idle");
  property p_reset_off;
    @(posedge clk) reset |-> low_byte_buffer_enable_n && high_byte_buffer_enable_n
      && swap_buffer_enable_n;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("buffer on in reset");
  property p_dma16;
    @(posedge clk) mode == dsc_pkg::DSC_MODE_DMA16 |-> !byte_high_enable_n_out
      && byte_high_enable_n_oe;
  endproperty
  a_dma16: assert property (p_dma16)
    else $error("bhe not low in dma16");
  property p_dma8;
    @(posedge clk) mode == dsc_pkg::DSC_MODE_DMA8 |-> byte_high_enable_n_out == !sa0_in;
  endproperty
  a_dma8: assert property (p_dma8)
    else $error("bhe not inverse of sa0 in dma8");
  property p_cpu_bhe;
    @(posedge clk) mode == dsc_pkg::DSC_MODE_CPU |-> byte_high_enable_n_out == cpu_bhe_n
      && byte_high_enable_n_oe;
  endproperty
  a_cpu_bhe: assert property (p_cpu_bhe)
    else $error("bhe does not follow processor");
  property p_master;
    @(posedge clk) mode == dsc_pkg::DSC_MODE_MASTER |-> !byte_high_enable_n_oe;
  endproperty
  a_master: assert property (p_master)
    else $error("bhe driven in master");
  property p_latch_then_sel;
    @(posedge clk) disable iff (reset)
      low_byte_latch_clock && cycle_active |=> latched_byte_select;
  endproperty
  a_latch_then_sel: assert property (p_latch_then_sel)
    else $error("select missing");
endmodule

/* bench/dsc_mem_model.sv */
// Memory data bus model feeding words and stored parity to the steering block
`timescale 1ns/100ps
module dsc_mem_model (
  input wire logic [15:0] word,
  input wire logic flip,
  output logic [15:0] data,
  output logic [1:0] parity
);
  // ==========================================================
  // Stored parity as written, optionally corrupted on the low byte
  assign data = word;
  assign parity = {^word[15:8], (^word[7:0]) ^ flip};
endmodule

/* bench/dsc_data_steer_test.sv */
// Self-checking bench for the data steering and byte conversion block
`timescale 1ns/100ps
module dsc_data_steer_test;
  typedef struct packed {logic [1:0] md; logic sa; logic bh; logic [15:0] w;
    logic [3:0] e;} dsc_row_t;
  // Expected bits: output enable, byte high enable, high parity, low parity
  dsc_row_t rows [6] = '{'{2'h0, 1'b0, 1'b0, 16'h0001, 4'h9}, '{2'h0, 1'b0, 1'b1, 16'h0300, 4'hC},
    '{2'h1, 1'b0, 1'b0, 16'h0100, 4'hE}, '{2'h1, 1'b1, 1'b1, 16'hFF7F, 4'h9},
    '{2'h2, 1'b1, 1'b1, 16'h8001, 4'hB}, '{2'h3, 1'b0, 1'b0, 16'h0000, 4'h0}};
  logic clk, reset, cycle_active, cycle_start, cycle_read, cycle_mem, cycle_local_mem;
  logic cycle_peripheral, cycle_byte_port, rom_hit, cpu_ble_n, cpu_bhe_n, sa0_in;
  logic ext_data_controller, system_port_parity_check_enable, chipset_parity_enable;
  logic rom_output_enable_n_pin, byte_high_enable_n_in, flip, seen;
  logic [3:0] rom_wait_states;
  logic [15:0] word, mem_data_in;
  logic [1:0] mem_parity_in;
  dsc_pkg::dsc_mode_t mode;
  logic rom_output_enable_n, rom8_mode, sa0_out, rom_ready, low_byte_parity, high_byte_parity;
  logic parity_nmi, low_byte_buffer_enable_n, high_byte_buffer_enable_n, swap_buffer_enable_n;
  logic processor_read_direction_n, swap_direction, peripheral_buffer_read_n;
  logic memory_data_direction_n, low_byte_latch_clock, latched_byte_select;
  logic byte_high_enable_n_out, byte_high_enable_n_oe;
  wire [2:0] bufs_n = {low_byte_buffer_enable_n, high_byte_buffer_enable_n, swap_buffer_enable_n};
  wire [2:0] oe_par = {byte_high_enable_n_oe, high_byte_parity, low_byte_parity};
  wire [4:0] dirs = {rom_output_enable_n, processor_read_direction_n, swap_direction,
    peripheral_buffer_read_n, memory_data_direction_n};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  dsc_data_steer dut (.*);
  dsc_mem_model mem (.word(word), .flip(flip), .data(mem_data_in), .parity(mem_parity_in));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Ceiling well above the longest run so a hang still gets a verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
  begin
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  end
  endtask
  // Strap pin must sit still for the whole reset so capture agrees
  task automatic do_reset(input logic pin);
  begin
    @(posedge clk);
    reset <= 1'b1;
    rom_output_enable_n_pin <= pin;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
  end
  endtask
  task automatic conv(input logic [3:0] w, input logic abort, input logic [7:0] exp_n);
    int n;
    logic saw;
  begin
    @(posedge clk);
    {cycle_active, cycle_start, cycle_read, cycle_mem, rom_hit, cpu_bhe_n} <= 6'h3E;
    rom_wait_states <= w;
    @(posedge clk);
    cycle_start <= 1'b0;
    #1 n = 0;
    saw = 1'b0;
    if (exp_n != 8'h28) chk(sa0_out, 1'b0);
    while (n < 40 && rom_ready !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (abort && n == 2) cycle_active <= 1'b0;
      #1 saw |= low_byte_latch_clock;
    end
    chk(8'(n), exp_n);
    if (exp_n != 8'h28)
    begin
      chk({saw, sa0_out, latched_byte_select}, 3'h7);
    end
    @(posedge clk);
    {cycle_active, cycle_read, cycle_mem, rom_hit, cpu_bhe_n} <= 5'h01;
    repeat (2) @(posedge clk);
  end
  endtask
  initial
  begin
    {reset, cycle_active, cycle_start, cycle_read, cycle_mem, cycle_local_mem} = 6'h20;
    {cycle_peripheral, cycle_byte_port, rom_hit, sa0_in, flip} = 5'h00;
    {cpu_ble_n, cpu_bhe_n, byte_high_enable_n_in, rom_output_enable_n_pin} = 4'hF;
    {ext_data_controller, system_port_parity_check_enable, chipset_parity_enable} = 3'h0;
    rom_wait_states = 4'h0;
    word = 16'h0000;
    mode = dsc_pkg::DSC_MODE_CPU;
    do_reset(1'b0);
    chk(rom8_mode, 1'b1);
    chk(bufs_n, 3'h7);
    foreach (rows[i])
    begin
      @(posedge clk);
      {cycle_active, cycle_mem, cpu_ble_n} <= 3'h6;
      mode <= dsc_pkg::dsc_mode_t'(rows[i].md);
      {sa0_in, cpu_bhe_n, word} <= {rows[i].sa, rows[i].bh, rows[i].w};
      @(posedge clk);
      #1 chk(oe_par, {rows[i].e[3], rows[i].e[1:0]});
      if (rows[i].md != 2'h3) chk(byte_high_enable_n_out, rows[i].e[2]);
    end
    @(posedge clk);
    {cycle_active, cycle_mem, cpu_ble_n, cpu_bhe_n} <= 4'h1;
    mode <= dsc_pkg::DSC_MODE_CPU;
    // Local memory and ROM cycle: directions follow the read flag, D to SD buffers stay off
    for (int r = 0; r < 2; r++)
    begin
      @(posedge clk);
      {cycle_active, cycle_read, cycle_peripheral, cycle_local_mem, rom_hit} <= {1'b1, r[0], 3'h7};
      @(posedge clk);
      #1 chk(dirs, {1'b0, {4{~r[0]}}});
      chk(bufs_n, 3'h7);
    end
    @(posedge clk);
    {cycle_local_mem, ext_data_controller, cycle_read} <= 3'h2;
    @(posedge clk);
    #1 chk(bufs_n, 3'h7);
    @(posedge clk);
    {ext_data_controller, cpu_bhe_n} <= 2'h0;
    @(posedge clk);
    #1 chk(bufs_n, 3'h1);
    @(posedge clk);
    {cycle_byte_port, cpu_ble_n} <= 2'h3;
    @(posedge clk);
    #1 chk(bufs_n, 3'h6);
    @(posedge clk);
    {cycle_active, cycle_peripheral, cycle_byte_port, rom_hit, cpu_ble_n, cpu_bhe_n} <= 6'h01;
    conv(4'h0, 1'b0, 8'h03);
    conv(4'hF, 1'b0, 8'h21);
    conv(4'h2, 1'b1, 8'h28);
    conv(4'h0, 1'b1, 8'h28);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {system_port_parity_check_enable, chipset_parity_enable} <= k[1:0];
      {cycle_active, cycle_start, cycle_read, cycle_mem, flip} <= 5'h1F;
      @(posedge clk);
      cycle_start <= 1'b0;
      seen = 1'b0;
      repeat (4) @(posedge clk) #1 seen |= parity_nmi;
      chk(seen, k == 3);
      {cycle_active, cycle_read, cycle_mem, flip} <= 4'h0;
      repeat (3) @(posedge clk);
      #1 chk(parity_nmi, 1'b0);
    end
    do_reset(1'b1);
    chk(rom8_mode, 1'b0);
    conv(4'h0, 1'b0, 8'h28);
    stop_test();
  end
endmodule
